// ==== vdm_cfg.svh ====
`ifndef VDM_CFG_SVH
`define VDM_CFG_SVH

// Message header fields
`define MH_CNT_MSB 14
`define MH_CNT_LSB 12
`define MH_ID_MSB 11
`define MH_ID_LSB 9
`define MH_ROLE_BIT 8
`define MH_REV_MSB 7
`define MH_REV_LSB 6
`define MH_TYPE_MSB 3
`define MH_TYPE_LSB 0
`define MH_TYPE_VDM 4'hf
`define MH_SPEC_REV 2'h1

// VDM header fields
`define VH_SVID_MSB 31
`define VH_SVID_LSB 16
`define VH_STRUCT_BIT 15
`define VH_VER_MSB 14
`define VH_VER_LSB 13
`define VH_POS_MSB 10
`define VH_POS_LSB 8
`define VH_CT_MSB 7
`define VH_CT_LSB 6
`define VH_SRC_BIT 5
`define VH_CMD_MSB 4
`define VH_CMD_LSB 0
`define VH_VERSION 2'h0

`define CMD_DISC_MODES 5'h03
`define CMD_ENTER_MODE 5'h04
`define CT_INIT 2'h0
`define CT_ACK 2'h1
`define SRC_INIT 1'h0
`define SRC_RESP 1'h1
`define POS_NONE 3'h0
`define POS_FIRST 3'h1

`define MAX_MODES 3'h6
`define ONE_OBJ 3'h1

`endif

// ==== vdm_pkg.sv ====
package vdm_pkg;
   typedef logic [31:0] word_t;
   // One-bit steps: idle -> send -> wait, idle -> reply -> idle; wait -> idle flips both bits
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_WAIT = 2'b11,
      ST_REPLY = 2'b10
   } fsm_state_t;
endpackage

// ==== vdm_tx_framer.sv ====
`timescale 1ns/1ns
`include "vdm_cfg.svh"
module vdm_tx_framer (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic [15:0] msg_hdr_i,
   input wire logic [223:0] words_i,
   input wire logic [2:0] nobj_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic tx_first_o,
   output logic tx_last_o,
   output logic [15:0] tx_msg_hdr_o,
   output logic [31:0] tx_data_o
);
   vdm_pkg::word_t words [7];
   vdm_pkg::word_t next_words [7];
   logic [2:0] idx, next_idx, nobj, next_nobj;
   logic next_valid, next_first, next_last;
   logic [15:0] next_hdr;
   logic [31:0] next_data;

   always_comb begin
      next_words = words;
      next_idx = idx;
      next_nobj = nobj;
      next_valid = tx_valid_o;
      next_first = tx_first_o;
      next_last = tx_last_o;
      next_hdr = tx_msg_hdr_o;
      next_data = tx_data_o;
      if (start_i && !tx_valid_o) begin
         for (int k = 0; k < 7; k++) begin
            next_words[k] = words_i[32*k +: 32];
         end
         next_nobj = nobj_i;
         next_valid = 1'b1;
         next_first = 1'b1;
         next_last = (nobj_i == `ONE_OBJ);
         next_hdr = msg_hdr_i;
         next_data = words_i[31:0];
         next_idx = `ONE_OBJ;
      end else if (tx_valid_o && tx_ready_i) begin
         next_first = 1'b0;
         if (tx_last_o) begin
            next_valid = 1'b0;
            next_last = 1'b0;
         end else begin
            next_data = words[idx];
            next_last = (3'(idx + 3'h1) == nobj);
            next_idx = 3'(idx + 3'h1);
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         words <= '{default: 32'h0};
         idx <= 3'h0;
         nobj <= 3'h0;
         tx_valid_o <= 1'b0;
         tx_first_o <= 1'b0;
         tx_last_o <= 1'b0;
         tx_msg_hdr_o <= 16'h0;
         tx_data_o <= 32'h0;
      end else if (ce_i) begin
         words <= next_words;
         idx <= next_idx;
         nobj <= next_nobj;
         tx_valid_o <= next_valid;
         tx_first_o <= next_first;
         tx_last_o <= next_last;
         tx_msg_hdr_o <= next_hdr;
         tx_data_o <= next_data;
      end
   end
endmodule

// ==== vdm_rx_deframer.sv ====
`timescale 1ns/1ns
`include "vdm_cfg.svh"
module vdm_rx_deframer (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic rx_valid_i,
   input wire logic rx_first_i,
   input wire logic rx_last_i,
   input wire logic [15:0] rx_msg_hdr_i,
   input wire logic [31:0] rx_data_i,
   output logic done_o,
   output logic ok_o,
   output logic [223:0] words_o,
   output logic [2:0] nobj_o
);
   logic [3:0] cnt, next_cnt, slot;
   logic [15:0] hdr, next_hdr, hdr_now;
   logic ovf, next_ovf;
   logic next_done, next_ok;
   logic [223:0] next_words;
   logic [2:0] next_nobj;
   logic [31:0] vdm_now;

   always_comb begin
      next_cnt = cnt;
      next_hdr = hdr;
      next_ovf = ovf;
      next_words = words_o;
      next_nobj = nobj_o;
      next_done = 1'b0;
      next_ok = ok_o;
      slot = rx_first_i ? 4'h0 : cnt;
      hdr_now = rx_first_i ? rx_msg_hdr_i : hdr;
      vdm_now = rx_first_i ? rx_data_i : words_o[31:0];
      if (rx_valid_i) begin
         if (rx_first_i) begin
            next_hdr = rx_msg_hdr_i;
            next_ovf = 1'b0;
         end
         // Words past the seventh are dropped and poison the frame
         if (slot < 4'h7) begin
            next_words[32*slot[2:0] +: 32] = rx_data_i;
            next_cnt = 4'(slot + 4'h1);
         end else begin
            next_ovf = 1'b1;
         end
         if (rx_last_i) begin
            next_done = 1'b1;
            next_nobj = next_cnt[2:0];
            next_ok = !next_ovf
               && hdr_now[`MH_TYPE_MSB:`MH_TYPE_LSB] == `MH_TYPE_VDM
               && hdr_now[`MH_CNT_MSB:`MH_CNT_LSB] == next_cnt[2:0]
               && vdm_now[`VH_STRUCT_BIT];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt <= 4'h0;
         hdr <= 16'h0;
         ovf <= 1'b0;
         done_o <= 1'b0;
         ok_o <= 1'b0;
         words_o <= 224'h0;
         nobj_o <= 3'h0;
      end else if (ce_i) begin
         cnt <= next_cnt;
         hdr <= next_hdr;
         ovf <= next_ovf;
         done_o <= next_done;
         ok_o <= next_ok;
         words_o <= next_words;
         nobj_o <= next_nobj;
      end
   end
endmodule

// ==== structured_vdm_mode_discovery.sv ====
// Functional notes
// - Discovery request carries one object, the VDM header only.
// - Initiator requests set command type bits 7..6 to zero.
// - Discovery request uses command code 3 in bits 4..0.
// - All these messages use message type 1111b.
// - Discovery request puts the asked SVID in bits 31..16.
// - Discovery reply object count is modes plus one, 1 to 7.
// - Responder replies set bit 5 of the VDM header to one.
// - A discovery reply holds at most six modes.
// - Vendor mode objects pass through uninterpreted.
// - Standard mode objects follow their standard, supplied by the user.
// - Each mode object fills all 32 bits.
// - Discovery reply echoes the requested SVID in bits 31..16.
// - Entry request has one object and command code 4.
// - Entry request sets bit 5 of the VDM header to zero.
// - Entry request object position names the discovered mode offset.
// - Position 001b selects the first discovered mode, upward in order.
// - Entry request carries the owning SVID in bits 31..16.
// - Responder that entered replies with one object and command 4.
`timescale 1ns/1ns
`include "vdm_cfg.svh"
module structured_vdm_mode_discovery (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [2:0] msg_id_i,
   input wire logic power_role_i,
   input wire logic disc_req_i,
   input wire logic [15:0] disc_svid_i,
   input wire logic enter_req_i,
   input wire logic [15:0] enter_svid_i,
   input wire logic [2:0] enter_pos_i,
   input wire logic cancel_i,
   input wire logic [15:0] own_svid_i,
   input wire logic [2:0] own_mode_count_i,
   input wire logic [191:0] own_modes_i,
   input wire logic [2:0] mode_rd_idx_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic tx_first_o,
   output logic tx_last_o,
   output logic [15:0] tx_msg_hdr_o,
   output logic [31:0] tx_data_o,
   input wire logic rx_valid_i,
   input wire logic rx_first_i,
   input wire logic rx_last_i,
   input wire logic [15:0] rx_msg_hdr_i,
   input wire logic [31:0] rx_data_i,
   output logic busy_o,
   output logic disc_done_o,
   output logic [2:0] mode_count_o,
   output logic [31:0] mode_rd_data_o,
   output logic enter_done_o,
   output logic req_err_o,
   output logic mode_entered_o,
   output logic [15:0] entered_svid_o,
   output logic [2:0] entered_pos_o
);
   vdm_pkg::fsm_state_t state, next_state;
   vdm_pkg::word_t modes [6];
   vdm_pkg::word_t next_modes [6];
   logic op_enter, next_op_enter;
   logic [15:0] req_svid, next_req_svid;
   logic [2:0] req_pos, next_req_pos;
   logic [2:0] next_mode_count;
   logic [31:0] next_rd_data;
   logic next_disc_done, next_enter_done, next_req_err, next_entered;
   logic [15:0] next_ent_svid;
   logic [2:0] next_ent_pos;
   logic launch;
   logic [15:0] launch_hdr;
   logic [223:0] launch_words;
   logic [2:0] launch_nobj;
   logic rx_done, rx_ok;
   logic [223:0] rx_words;
   logic [2:0] rx_nobj;
   logic [15:0] rx_svid;
   logic [2:0] rx_pos;
   logic [1:0] rx_ct;
   logic [4:0] rx_cmd;

   function automatic logic [31:0] vdm_hdr(input logic [15:0] svid, input logic [2:0] pos,
                                           input logic [1:0] ct, input logic src, input logic [4:0] cmd);
      logic [31:0] h;
      h = 32'h0; // Reserved bits stay zero
      h[`VH_SVID_MSB:`VH_SVID_LSB] = svid;
      h[`VH_STRUCT_BIT] = 1'b1;
      h[`VH_VER_MSB:`VH_VER_LSB] = `VH_VERSION;
      h[`VH_POS_MSB:`VH_POS_LSB] = pos;
      h[`VH_CT_MSB:`VH_CT_LSB] = ct;
      h[`VH_SRC_BIT] = src;
      h[`VH_CMD_MSB:`VH_CMD_LSB] = cmd;
      return h;
   endfunction

   function automatic logic [15:0] msg_hdr(input logic [2:0] cnt, input logic [2:0] id, input logic role);
      logic [15:0] m;
      m = 16'h0;
      m[`MH_CNT_MSB:`MH_CNT_LSB] = cnt;
      m[`MH_ID_MSB:`MH_ID_LSB] = id;
      m[`MH_ROLE_BIT] = role;
      m[`MH_REV_MSB:`MH_REV_LSB] = `MH_SPEC_REV;
      m[`MH_TYPE_MSB:`MH_TYPE_LSB] = `MH_TYPE_VDM;
      return m;
   endfunction

   vdm_tx_framer u_tx (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .start_i(launch),
      .msg_hdr_i(launch_hdr),
      .words_i(launch_words),
      .nobj_i(launch_nobj),
      .tx_ready_i(tx_ready_i),
      .tx_valid_o(tx_valid_o),
      .tx_first_o(tx_first_o),
      .tx_last_o(tx_last_o),
      .tx_msg_hdr_o(tx_msg_hdr_o),
      .tx_data_o(tx_data_o)
   );

   vdm_rx_deframer u_rx (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .rx_valid_i(rx_valid_i),
      .rx_first_i(rx_first_i),
      .rx_last_i(rx_last_i),
      .rx_msg_hdr_i(rx_msg_hdr_i),
      .rx_data_i(rx_data_i),
      .done_o(rx_done),
      .ok_o(rx_ok),
      .words_o(rx_words),
      .nobj_o(rx_nobj)
   );

   assign rx_svid = rx_words[`VH_SVID_MSB:`VH_SVID_LSB];
   assign rx_pos = rx_words[`VH_POS_MSB:`VH_POS_LSB];
   assign rx_ct = rx_words[`VH_CT_MSB:`VH_CT_LSB];
   assign rx_cmd = rx_words[`VH_CMD_MSB:`VH_CMD_LSB];

   always_comb begin
      next_state = state;
      for (int k = 0; k < 6; k++) begin
         next_modes[k] = modes[k];
      end
      next_op_enter = op_enter;
      next_req_svid = req_svid;
      next_req_pos = req_pos;
      next_mode_count = mode_count_o;
      next_disc_done = 1'b0;
      next_enter_done = 1'b0;
      next_req_err = 1'b0;
      next_entered = mode_entered_o;
      next_ent_svid = entered_svid_o;
      next_ent_pos = entered_pos_o;
      launch = 1'b0;
      launch_hdr = 16'h0;
      launch_words = 224'h0;
      launch_nobj = `ONE_OBJ;
      case (state)
         vdm_pkg::ST_IDLE: begin
            if (disc_req_i) begin
               launch = 1'b1;
               launch_hdr = msg_hdr(`ONE_OBJ, msg_id_i, power_role_i);
               launch_words[31:0] = vdm_hdr(disc_svid_i, `POS_NONE, `CT_INIT, `SRC_INIT, `CMD_DISC_MODES);
               next_op_enter = 1'b0;
               next_req_svid = disc_svid_i;
               next_state = vdm_pkg::ST_SEND;
            end else if (enter_req_i) begin
               // Position must lie inside the discovered list
               if (enter_pos_i == `POS_NONE || enter_pos_i > mode_count_o) begin
                  next_req_err = 1'b1;
               end else begin
                  launch = 1'b1;
                  launch_hdr = msg_hdr(`ONE_OBJ, msg_id_i, power_role_i);
                  launch_words[31:0] = vdm_hdr(enter_svid_i, enter_pos_i, `CT_INIT, `SRC_INIT, `CMD_ENTER_MODE);
                  next_op_enter = 1'b1;
                  next_req_svid = enter_svid_i;
                  next_req_pos = enter_pos_i;
                  next_state = vdm_pkg::ST_SEND;
               end
            end else if (rx_done && rx_ok && rx_ct == `CT_INIT && rx_svid == own_svid_i) begin
               if (rx_cmd == `CMD_DISC_MODES && rx_nobj == `ONE_OBJ && own_mode_count_i <= `MAX_MODES) begin
                  launch = 1'b1;
                  launch_nobj = 3'(own_mode_count_i + 3'h1);
                  launch_hdr = msg_hdr(launch_nobj, msg_id_i, power_role_i);
                  launch_words[31:0] = vdm_hdr(rx_svid, `POS_NONE, `CT_ACK, `SRC_RESP, `CMD_DISC_MODES);
                  // Mode words go out verbatim
                  launch_words[223:32] = own_modes_i;
                  next_state = vdm_pkg::ST_REPLY;
               end else if (rx_cmd == `CMD_ENTER_MODE && rx_nobj == `ONE_OBJ && rx_pos != `POS_NONE
                            && rx_pos <= own_mode_count_i) begin
                  launch = 1'b1;
                  launch_hdr = msg_hdr(`ONE_OBJ, msg_id_i, power_role_i);
                  launch_words[31:0] = vdm_hdr(rx_svid, rx_pos, `CT_ACK, `SRC_RESP, `CMD_ENTER_MODE);
                  next_entered = 1'b1;
                  next_ent_svid = rx_svid;
                  next_ent_pos = rx_pos;
                  next_state = vdm_pkg::ST_REPLY;
               end
            end
         end
         vdm_pkg::ST_SEND: begin
            if (!tx_valid_o) begin
               next_state = vdm_pkg::ST_WAIT;
            end
         end
         vdm_pkg::ST_WAIT: begin
            if (cancel_i) begin
               next_state = vdm_pkg::ST_IDLE;
            end else if (rx_done && rx_ok && rx_ct != `CT_INIT && rx_svid == req_svid
                         && rx_cmd == (op_enter ? `CMD_ENTER_MODE : `CMD_DISC_MODES)) begin
               next_state = vdm_pkg::ST_IDLE;
               if (rx_ct != `CT_ACK) begin
                  next_req_err = 1'b1;
               end else if (!op_enter) begin
                  // Slot k is object position k+1
                  for (int k = 0; k < 6; k++) begin
                     next_modes[k] = (3'(k + 1) < rx_nobj) ? rx_words[32*(k+1) +: 32] : 32'h0;
                  end
                  next_mode_count = 3'(rx_nobj - 3'h1);
                  next_disc_done = 1'b1;
               end else if (rx_nobj == `ONE_OBJ && rx_pos == req_pos) begin
                  next_entered = 1'b1;
                  next_ent_svid = req_svid;
                  next_ent_pos = req_pos;
                  next_enter_done = 1'b1;
               end else begin
                  next_req_err = 1'b1;
               end
            end
         end
         vdm_pkg::ST_REPLY: begin
            if (!tx_valid_o) begin
               next_state = vdm_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = vdm_pkg::ST_IDLE;
         end
      endcase
      next_rd_data = 32'h0;
      if (mode_rd_idx_i != `POS_NONE && mode_rd_idx_i <= mode_count_o) begin
         next_rd_data = modes[3'(mode_rd_idx_i - `POS_FIRST)];
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= vdm_pkg::ST_IDLE;
         for (int k = 0; k < 6; k++) begin
            modes[k] <= 32'h0;
         end
         op_enter <= 1'b0;
         req_svid <= 16'h0;
         req_pos <= 3'h0;
         busy_o <= 1'b0;
         mode_count_o <= 3'h0;
         mode_rd_data_o <= 32'h0;
         disc_done_o <= 1'b0;
         enter_done_o <= 1'b0;
         req_err_o <= 1'b0;
         mode_entered_o <= 1'b0;
         entered_svid_o <= 16'h0;
         entered_pos_o <= 3'h0;
      end else if (ce_i) begin
         state <= next_state;
         modes <= next_modes;
         op_enter <= next_op_enter;
         req_svid <= next_req_svid;
         req_pos <= next_req_pos;
         busy_o <= (next_state != vdm_pkg::ST_IDLE);
         mode_count_o <= next_mode_count;
         mode_rd_data_o <= next_rd_data;
         disc_done_o <= next_disc_done;
         enter_done_o <= next_enter_done;
         req_err_o <= next_req_err;
         mode_entered_o <= next_entered;
         entered_svid_o <= next_ent_svid;
         entered_pos_o <= next_ent_pos;
      end
   end
endmodule

// ==== vdm_mode_chk.sv ====
`timescale 1ns/1ns
module vdm_mode_chk (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic disc_req_i,
   input wire logic [15:0] disc_svid_i,
   input wire logic enter_req_i,
   input wire logic [15:0] enter_svid_i,
   input wire logic [2:0] enter_pos_i,
   input wire logic [15:0] own_svid_i,
   input wire logic tx_valid_o,
   input wire logic tx_first_o,
   input wire logic tx_last_o,
   input wire logic [15:0] tx_msg_hdr_o,
   input wire logic [31:0] tx_data_o,
   input wire logic busy_o,
   input wire logic disc_done_o,
   input wire logic [2:0] mode_count_o,
   input wire logic req_err_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   wire ack = tx_valid_o && tx_first_o && tx_data_o[7:6] == 2'h1;
   wire req = tx_valid_o && tx_first_o && tx_data_o[7:6] == 2'h0;

   disc_one_a: assert property (req && tx_data_o[4:0] == 5'h03 |-> tx_last_o && tx_msg_hdr_o[14:12] == 3'h1)
      else $error("request size");
   msg_type_a: assert property (tx_valid_o |-> tx_msg_hdr_o[3:0] == 4'hf)
      else $error("message type");
   disc_launch_a: assert property (ce_i && !busy_o && disc_req_i |=> tx_valid_o && tx_first_o && tx_data_o == {$past(disc_svid_i), 16'h8003})
      else $error("discovery header");
   enter_launch_a: assert property (ce_i && !busy_o && !disc_req_i && enter_req_i && enter_pos_i != 3'h0 &&
      enter_pos_i <= mode_count_o |=> tx_valid_o && tx_last_o && tx_data_o == {$past(enter_svid_i), 5'h10, $past(enter_pos_i), 8'h04})
      else $error("entry header");
   resp_src_a: assert property (ack |-> tx_data_o[5] && tx_data_o[31:16] == own_svid_i)
      else $error("reply source");
   reply_count_a: assert property (ack && tx_data_o[4:0] == 5'h03 |-> tx_msg_hdr_o[14:12] != 3'h0 && tx_data_o[15:8] == 8'h80)
      else $error("reply count");
   enter_ack_a: assert property (ack && tx_data_o[4:0] == 5'h04 |-> tx_last_o && tx_msg_hdr_o[14:12] == 3'h1)
      else $error("entry reply size");
   init_src_a: assert property (req |-> !tx_data_o[5] && tx_data_o[15])
      else $error("request source");
   six_max_a: assert property (disc_done_o |-> mode_count_o <= 3'h6)
      else $error("mode count");
   bad_pos_a: assert property (ce_i && !busy_o && !disc_req_i && enter_req_i && enter_pos_i == 3'h0 |-> ##[1:3] req_err_o)
      else $error("position zero");
endmodule

bind structured_vdm_mode_discovery vdm_mode_chk i_vdm_mode_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
   .disc_req_i(disc_req_i), .disc_svid_i(disc_svid_i), .enter_req_i(enter_req_i), .enter_svid_i(enter_svid_i),
   .enter_pos_i(enter_pos_i), .own_svid_i(own_svid_i), .tx_valid_o(tx_valid_o), .tx_first_o(tx_first_o),
   .tx_last_o(tx_last_o), .tx_msg_hdr_o(tx_msg_hdr_o), .tx_data_o(tx_data_o), .busy_o(busy_o),
   .disc_done_o(disc_done_o), .mode_count_o(mode_count_o), .req_err_o(req_err_o));

// ==== vdm_link_partner.sv ====
`timescale 1ns/1ns
module vdm_link_partner (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic tx_valid_i,
   input wire logic tx_first_i,
   input wire logic [31:0] tx_data_i,
   input wire logic slow_i,
   input wire logic nak_i,
   input wire logic [2:0] nmodes_i,
   input wire logic inj_i,
   input wire logic [15:0] inj_hdr_i,
   input wire logic [31:0] inj_data_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output logic rx_first_o,
   output logic rx_last_o,
   output logic [15:0] rx_msg_hdr_o,
   output logic [31:0] rx_data_o
);
   logic [31:0] req;
   logic [3:0] k;
   logic [2:0] n;
   logic pend, ph;
   assign tx_ready_o = !slow_i || ph;
   assign n = (req[4:0] == 5'h03) ? nmodes_i : 3'h0;
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req <= 32'h0;
         k <= 4'h0;
         pend <= 1'b0;
         ph <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_first_o <= 1'b0;
         rx_last_o <= 1'b0;
         rx_msg_hdr_o <= 16'h0;
         rx_data_o <= 32'h0;
      end else begin
         ph <= !ph;
         rx_valid_o <= 1'b0;
         rx_first_o <= 1'b0;
         rx_last_o <= 1'b0;
         rx_data_o <= ~rx_data_o;
         rx_msg_hdr_o <= ~rx_msg_hdr_o;
         if (tx_valid_i && tx_ready_o && tx_first_i && tx_data_i[7:6] == 2'h0) begin
            req <= tx_data_i;
            pend <= 1'b1;
            k <= 4'hd;
         end else if (pend && k[3]) begin
            k <= k + 4'h1;
         end else if (pend) begin
            rx_valid_o <= 1'b1;
            rx_first_o <= (k == 4'h0);
            rx_last_o <= (k[2:0] == n);
            rx_msg_hdr_o <= {1'b0, n + 3'h1, 3'h0, 1'b0, 2'h1, 2'h0, 4'hf};
            rx_data_o <= (k == 4'h0) ? {req[31:16], 1'b1, 4'h0, req[10:8], nak_i ? 2'h2 : 2'h1, 1'b1, req[4:0]}
                                     : {req[31:16], 13'h0, k[2:0]};
            k <= k + 4'h1;
            pend <= (k[2:0] != n);
         end else if (inj_i) begin
            rx_valid_o <= 1'b1;
            rx_first_o <= 1'b1;
            rx_last_o <= 1'b1;
            rx_msg_hdr_o <= inj_hdr_i;
            rx_data_o <= inj_data_i;
         end
      end
   end
endmodule

// ==== tb_structured_vdm_mode_discovery.sv ====
`timescale 1ns/1ns
module tb_structured_vdm_mode_discovery;
   typedef struct packed {logic [15:0] svid; logic [2:0] nm; logic [2:0] pos; logic slow; logic [2:0] cnt;} row_t;
   row_t rows [3] = '{'{16'hff01, 3'h1, 3'h1, 1'b0, 3'h1}, '{16'h1234, 3'h6, 3'h6, 1'b1, 3'h6},
                      '{16'hab00, 3'h3, 3'h2, 1'b1, 3'h3}};
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ce_i = 1'b1;
   logic [2:0] msg_id_i = 3'h5;
   logic power_role_i = 1'b1;
   logic disc_req_i = 1'b0;
   logic [15:0] disc_svid_i = 16'h0;
   logic enter_req_i = 1'b0;
   logic [15:0] enter_svid_i = 16'h0;
   logic [2:0] enter_pos_i = 3'h0;
   logic cancel_i = 1'b0;
   logic [15:0] own_svid_i = 16'hc0de;
   logic [2:0] own_mode_count_i = 3'h2;
   logic [191:0] own_modes_i = {128'h0, 32'h3c3c_0202, 32'h5a5a_0101};
   logic [2:0] mode_rd_idx_i = 3'h0;
   logic tx_ready_i, tx_valid_o, tx_first_o, tx_last_o, rx_valid_i, rx_first_i, rx_last_i;
   logic [15:0] tx_msg_hdr_o, rx_msg_hdr_i, entered_svid_o;
   logic [31:0] tx_data_o, rx_data_i, mode_rd_data_o;
   logic busy_o, disc_done_o, enter_done_o, req_err_o, mode_entered_o;
   logic [2:0] mode_count_o, entered_pos_o;
   logic slow = 1'b0, nak = 1'b0, inj = 1'b0;
   logic [2:0] nmodes = 3'h0;
   logic [31:0] inj_data = 32'h0;
   logic [31:0] txq [$];
   logic [15:0] txhdr;
   int bad_count = 0;
   int samples_checked = 0;
   wire [2:0] evt = {req_err_o, enter_done_o, disc_done_o};
   always #5 core_clk_i = ~core_clk_i;

   structured_vdm_mode_discovery i_structured_vdm_mode_discovery (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .ce_i(ce_i), .msg_id_i(msg_id_i), .power_role_i(power_role_i), .disc_req_i(disc_req_i),
      .disc_svid_i(disc_svid_i), .enter_req_i(enter_req_i), .enter_svid_i(enter_svid_i), .enter_pos_i(enter_pos_i),
      .cancel_i(cancel_i), .own_svid_i(own_svid_i), .own_mode_count_i(own_mode_count_i), .own_modes_i(own_modes_i),
      .mode_rd_idx_i(mode_rd_idx_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o), .tx_first_o(tx_first_o),
      .tx_last_o(tx_last_o), .tx_msg_hdr_o(tx_msg_hdr_o), .tx_data_o(tx_data_o), .rx_valid_i(rx_valid_i),
      .rx_first_i(rx_first_i), .rx_last_i(rx_last_i), .rx_msg_hdr_i(rx_msg_hdr_i), .rx_data_i(rx_data_i),
      .busy_o(busy_o), .disc_done_o(disc_done_o), .mode_count_o(mode_count_o), .mode_rd_data_o(mode_rd_data_o),
      .enter_done_o(enter_done_o), .req_err_o(req_err_o), .mode_entered_o(mode_entered_o),
      .entered_svid_o(entered_svid_o), .entered_pos_o(entered_pos_o));
   vdm_link_partner i_vdm_link_partner (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .tx_valid_i(tx_valid_o),
      .tx_first_i(tx_first_o), .tx_data_i(tx_data_o), .slow_i(slow), .nak_i(nak), .nmodes_i(nmodes), .inj_i(inj),
      .inj_hdr_i(16'h124f), .inj_data_i(inj_data), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
      .rx_first_o(rx_first_i), .rx_last_o(rx_last_i), .rx_msg_hdr_o(rx_msg_hdr_i), .rx_data_o(rx_data_i));

   always @(posedge core_clk_i) begin
      if (ce_i && tx_valid_o && tx_ready_i) begin
         if (tx_first_o) begin
            txq.delete();
            txhdr <= tx_msg_hdr_o;
         end
         txq.push_back(tx_data_o);
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic await(input int b, input string name);
      int n = 0;
      while (evt[b] !== 1'b1 && n < 300) begin
         @(negedge core_clk_i);
         n++;
      end
      chk(name, evt[b], 1'b1);
   endtask

   task automatic request(input logic disc, input logic [15:0] svid, input logic [2:0] pos);
      @(negedge core_clk_i);
      disc_svid_i = svid;
      enter_svid_i = svid;
      enter_pos_i = pos;
      disc_req_i = disc;
      enter_req_i = !disc;
      @(negedge core_clk_i);
      disc_req_i = 1'b0;
      enter_req_i = 1'b0;
   endtask

   task automatic inject(input logic [31:0] w);
      int n;
      @(negedge core_clk_i);
      inj_data = w;
      inj = 1'b1;
      @(negedge core_clk_i);
      inj = 1'b0;
      for (n = 0; n < 20 && busy_o !== 1'b1; n++) @(negedge core_clk_i);
      for (n = 0; n < 300 && busy_o !== 1'b0; n++) @(negedge core_clk_i);
      @(negedge core_clk_i);
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #500000;
      bad_count++;
      end_sim();
   end

   initial begin
      repeat (4) @(negedge core_clk_i);
      chk("reset state", {tx_valid_o, busy_o, mode_entered_o, mode_count_o}, 32'h0);
      nrst_i = 1'b1;
      foreach (rows[r]) begin
         nmodes = rows[r].nm;
         slow = rows[r].slow;
         request(1'b1, rows[r].svid, 3'h0);
         await(0, "disc done");
         chk("disc msg hdr", txhdr, {1'b0, 3'h1, msg_id_i, power_role_i, 8'h4f});
         chk("disc vdm hdr", txq[0], {rows[r].svid, 16'h8003});
         chk("mode count", mode_count_o, rows[r].cnt);
         for (int i = 1; i < 8; i++) begin
            mode_rd_idx_i = 3'(i);
            @(negedge core_clk_i);
            chk("mode word", mode_rd_data_o, (i <= rows[r].nm) ? {rows[r].svid, 13'h0, 3'(i)} : 32'h0);
         end
         request(1'b0, rows[r].svid, rows[r].pos);
         await(1, "enter done");
         chk("enter vdm hdr", txq[0], {rows[r].svid, 5'h10, rows[r].pos, 8'h04});
         chk("enter msg hdr", txhdr, {1'b0, 3'h1, msg_id_i, power_role_i, 8'h4f});
         chk("entered", {mode_entered_o, entered_svid_o, entered_pos_o}, {1'b1, rows[r].svid, rows[r].pos});
      end
      request(1'b0, 16'hab00, 3'h0);
      await(2, "pos zero");
      request(1'b0, 16'hab00, 3'h4);
      await(2, "pos past list");
      nak = 1'b1;
      request(1'b0, 16'hab00, 3'h1);
      await(2, "nak");
      nak = 1'b0;
      inject({16'hc0de, 16'h8003});
      chk("reply size", txq.size(), 32'h3);
      chk("reply msg hdr", txhdr, {1'b0, 3'h3, msg_id_i, power_role_i, 8'h4f});
      chk("reply vdm hdr", txq[0], {16'hc0de, 16'h8063});
      chk("reply mode 1", txq[1], own_modes_i[31:0]);
      chk("reply mode 2", txq[2], own_modes_i[63:32]);
      inject({16'hc0de, 16'h8204});
      chk("enter ack", txq[0], {16'hc0de, 16'h8264});
      chk("enter ack size", txq.size(), 32'h1);
      chk("resp entered", {entered_svid_o, entered_pos_o}, {16'hc0de, 3'h2});
      txq.delete();
      inject({16'h1234, 16'h8003});
      chk("foreign svid", txq.size(), 32'h0);
      request(1'b1, 16'hab00, 3'h0);
      cancel_i = 1'b1;
      repeat (5) @(negedge core_clk_i);
      chk("cancel", busy_o, 1'b0);
      end_sim();
   end
endmodule
